// ===== logic/rsx_exec.sv
/*
 * executes push, pop, relative call, software reset, return from
 * interrupt and return with literal, one opcode per instruction cycle.
 * assumes OP_VALID marks a fetched opcode and PC_IN is its address.
 */
module rsx_exec
    import rsx_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // instruction
    input wire logic OP_VALID,
    input wire logic [15:0] OPCODE,
    input wire logic [rsx_pkg::PC_W-1:0] PC_IN,
    input wire logic HIGH_PRIO_ACTIVE,
    // software stack-top write
    input wire logic STACK_TOP_WR,
    input wire logic [rsx_pkg::PC_W-1:0] STACK_TOP_WDATA,
    // live register writes from the rest of the core
    input wire logic WORKING_WR,
    input wire logic [7:0] WORKING_WDATA,
    input wire logic SHADOW_WR,
    input wire logic [4:0] FLAGS_IN,
    input wire logic [3:0] BANK_IN,
    input wire logic ENABLES_CLR,
    // state
    output logic [rsx_pkg::PC_W-1:0] PC_OUT,
    output logic PC_LOAD,
    output logic BUSY,
    output logic SOFT_RESET,
    output logic [7:0] WORKING,
    output logic [4:0] FLAGS,
    output logic [3:0] BANK_SELECT_REG,
    output logic [7:0] WORKING_SHADOW,
    output logic [4:0] FLAGS_SHADOW,
    output logic [3:0] BANK_SELECT_SHADOW,
    output logic HIGH_PRIO_GLOBAL_ENABLE,
    output logic LOW_PRIO_GLOBAL_ENABLE,
    output logic [rsx_pkg::PC_W-1:0] STACK_TOP,
    output logic [rsx_pkg::PTR_W-1:0] STACK_PTR
);
    typedef struct packed {
        rsx_state_t state;
        logic [PC_W-1:0] pc;
        logic pc_load;
        logic busy;
        logic soft_reset;
        logic [7:0] w;
        logic [4:0] flags;
        logic [3:0] bank;
        logic [7:0] w_sh;
        logic [4:0] flags_sh;
        logic [3:0] bank_sh;
        logic en_hi;
        logic en_lo;
        logic [PC_W-1:0] top;
        logic [PTR_W-1:0] ptr;
    } rsx_exec_t;

    rsx_exec_t st_ff;
    rsx_exec_t nxt_st;

    logic stk_push;
    logic stk_pop;
    logic stk_rst;
    logic [PC_W-1:0] stk_top;
    logic [PTR_W-1:0] stk_ptr;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] call_dest;
    logic run;
    logic is_push;
    logic is_pop;
    logic is_reset;
    logic is_irq_ret;
    logic is_call;
    logic is_lit_ret;

    // opcode classes recognised by this block
    typedef enum logic [2:0] {
        RSX_K_NONE = 3'b000,
        RSX_K_PUSH = 3'b001,
        RSX_K_POP = 3'b010,
        RSX_K_RESET = 3'b011,
        RSX_K_IRQ_RET = 3'b100,
        RSX_K_CALL = 3'b101,
        RSX_K_LIT_RET = 3'b110
    } rsx_kind_t;

    rsx_kind_t kind;

    // sign-extended word offset times two
    function automatic logic [PC_W-1:0] word_ofs(input logic [OFS_W-1:0] n);
        word_ofs = {{(PC_W-OFS_W-1){n[OFS_W-1]}}, n, 1'b0};
    endfunction : word_ofs

    // sorts a fetched word into one class; the encodings never overlap
    function automatic rsx_kind_t op_kind(input logic [15:0] code);
        op_kind = RSX_K_NONE;
        if (code == OP_PUSH) begin
            op_kind = RSX_K_PUSH;
        end else if (code == OP_POP) begin
            op_kind = RSX_K_POP;
        end else if (code == OP_RESET) begin
            op_kind = RSX_K_RESET;
        end else if (code[15:1] == RETURN_FROM_IRQ_OP_HI) begin
            op_kind = RSX_K_IRQ_RET;
        end else if (code[15:11] == RELATIVE_CALL_OP_HI) begin
            op_kind = RSX_K_CALL;
        end else if (code[15:8] == RETURN_WITH_LITERAL_OP_HI) begin
            op_kind = RSX_K_LIT_RET;
        end
    endfunction : op_kind

    assign run = OP_VALID && (st_ff.state == RSX_RUN) && !st_ff.soft_reset;
    assign kind = run ? op_kind(OPCODE) : RSX_K_NONE;
    assign is_push = kind == RSX_K_PUSH;
    assign is_pop = kind == RSX_K_POP;
    assign is_reset = kind == RSX_K_RESET;
    assign is_irq_ret = kind == RSX_K_IRQ_RET;
    assign is_call = kind == RSX_K_CALL;
    assign is_lit_ret = kind == RSX_K_LIT_RET;
    assign ret_addr = PC_IN + PC_STEP;
    assign call_dest = ret_addr + word_ofs(OPCODE[OFS_W-1:0]);

    assign stk_push = is_push || is_call;
    assign stk_pop = is_pop || is_irq_ret || is_lit_ret;
    assign stk_rst = RST || st_ff.soft_reset;

    rsx_stack u_stack (
        .clk(REF_CLK),
        .rst(stk_rst),
        .push(stk_push),
        .pop(stk_pop),
        .push_val(ret_addr),
        .top_wr(STACK_TOP_WR),
        .top_val(STACK_TOP_WDATA),
        .top(stk_top),
        .ptr(stk_ptr)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pc_load = 1'b0;
        nxt_st.soft_reset = 1'b0;
        nxt_st.busy = 1'b0;
        nxt_st.state = RSX_RUN;
        if (WORKING_WR) begin
            nxt_st.w = WORKING_WDATA;
        end
        nxt_st.flags = FLAGS_IN;
        nxt_st.bank = BANK_IN;
        if (SHADOW_WR) begin
            nxt_st.w_sh = st_ff.w;
            nxt_st.flags_sh = FLAGS_IN;
            nxt_st.bank_sh = BANK_IN;
        end
        if (ENABLES_CLR) begin
            nxt_st.en_hi = 1'b0;
            nxt_st.en_lo = 1'b0;
        end
        if (is_call) begin
            nxt_st.pc = call_dest;
            nxt_st.pc_load = 1'b1;
            nxt_st.busy = 1'b1;
            nxt_st.state = RSX_IDLE;
        end else if (is_irq_ret) begin
            nxt_st.pc = stk_top;
            nxt_st.pc_load = 1'b1;
            nxt_st.busy = 1'b1;
            nxt_st.state = RSX_IDLE;
            if (HIGH_PRIO_ACTIVE) begin
                nxt_st.en_hi = 1'b1;
            end else begin
                nxt_st.en_lo = 1'b1;
            end
            if (OPCODE[0]) begin
                nxt_st.w = st_ff.w_sh;
                nxt_st.flags = st_ff.flags_sh;
                nxt_st.bank = st_ff.bank_sh;
            end
            // fast bit clear: live values kept as above
        end else if (is_lit_ret) begin
            nxt_st.w = OPCODE[7:0];
            nxt_st.pc = stk_top;
            nxt_st.pc_load = 1'b1; // pc latches are not driven
            nxt_st.busy = 1'b1;
            nxt_st.state = RSX_IDLE;
        end else if (is_reset) begin
            nxt_st.soft_reset = 1'b1;
        end
        nxt_st.top = stk_top;
        nxt_st.ptr = stk_ptr;
        if (st_ff.soft_reset) begin
            // the cycle after the reset opcode, with SOFT_RESET high, clears everything but pc_load, which it sets to load PC_RST
            nxt_st = '0;
            nxt_st.pc = PC_RST;
            nxt_st.pc_load = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_ff <= '0;
            st_ff.pc <= PC_RST;
            st_ff.w <= BYTE_RST;
            st_ff.flags <= FLAGS_RST;
            st_ff.bank <= BANK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PC_OUT = st_ff.pc;
    assign PC_LOAD = st_ff.pc_load;
    assign BUSY = st_ff.busy;
    assign SOFT_RESET = st_ff.soft_reset;
    assign WORKING = st_ff.w;
    assign FLAGS = st_ff.flags;
    assign BANK_SELECT_REG = st_ff.bank;
    assign WORKING_SHADOW = st_ff.w_sh;
    assign FLAGS_SHADOW = st_ff.flags_sh;
    assign BANK_SELECT_SHADOW = st_ff.bank_sh;
    assign HIGH_PRIO_GLOBAL_ENABLE = st_ff.en_hi;
    assign LOW_PRIO_GLOBAL_ENABLE = st_ff.en_lo;
    assign STACK_TOP = st_ff.top;
    assign STACK_PTR = st_ff.ptr;
endmodule : rsx_exec

// ===== logic/rsx_pkg.sv
/*
 * constants and types for the return-stack control-flow executor.
 * assumes a 21-bit program counter, a 31-entry return stack and
 * a core that hands one fetched opcode per instruction cycle.
 */
// Summary of operation
// - push writes the program counter plus two into the stack top.
// - push moves the old top one level deeper in one word and one cycle; at full the top entry is overwritten instead.
// - software may overwrite the stack top before a push to build a stack.
// - relative call holds an 11-bit signed word offset, -1024 to +1023.
// - relative call pushes the program counter plus two before jumping.
// - relative call loads pc+2+2n and spends a second, idle cycle.
// - software reset returns all master-clear registers to reset values.
// - return from interrupt pops the stack top into the program counter.
// - return from interrupt sets the high or low global enable with the pop.
// - with the fast bit set, shadow w, flags and bank select are restored.
// - with the fast bit clear, w, flags and bank select are untouched.
// - return with literal loads w with the opcode's 8-bit literal.
// - return with literal pops the stack into the pc, then idles a cycle.
// - return with literal leaves the high and upper pc latches alone.
package rsx_pkg;
    localparam int PC_W = 21;
    localparam int DEPTH = 31;
    localparam int PTR_W = 5;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
    localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
    localparam logic [PTR_W-1:0] PTR_FULL = 5'h1f;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam int OFS_W = 11;
    // opcode encodings
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_RESET = 16'h00ff;
    localparam logic [14:0] RETURN_FROM_IRQ_OP_HI = 15'h0008;
    localparam logic [4:0] RELATIVE_CALL_OP_HI = 5'h1b;
    localparam logic [7:0] RETURN_WITH_LITERAL_OP_HI = 8'h0c;

    typedef enum logic [1:0] {
        RSX_RUN = 2'b00,
        RSX_IDLE = 2'b01
    } rsx_state_t;
endpackage : rsx_pkg

// ===== logic/rsx_stack.sv
/*
 * return stack storage: flip-flop array addressed by pointer.
 * assumes the caller never asks for push and pop together.
 */
module rsx_stack
    import rsx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // operations
    input wire logic push,
    input wire logic pop,
    input wire logic [rsx_pkg::PC_W-1:0] push_val,
    input wire logic top_wr,
    input wire logic [rsx_pkg::PC_W-1:0] top_val,
    // state
    output logic [rsx_pkg::PC_W-1:0] top,
    output logic [rsx_pkg::PTR_W-1:0] ptr
);
    typedef struct packed {
        logic [DEPTH:1][PC_W-1:0] mem;
        logic [PTR_W-1:0] ptr;
    } rsx_stk_t;

    rsx_stk_t st_ff;
    rsx_stk_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            // pointer moves up unless full, so the old top sits one level deeper; at full the top entry is overwritten
            if (st_ff.ptr != PTR_FULL) begin
                nxt_st.ptr = st_ff.ptr + PTR_ONE;
            end
            nxt_st.mem[nxt_st.ptr] = push_val;
        end else if (pop) begin
            if (st_ff.ptr != PTR_EMPTY) begin
                nxt_st.ptr = st_ff.ptr - PTR_ONE;
            end
        end else if (top_wr && st_ff.ptr != PTR_EMPTY) begin
            nxt_st.mem[st_ff.ptr] = top_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign top = (st_ff.ptr == PTR_EMPTY) ? PC_RST : st_ff.mem[st_ff.ptr];
    assign ptr = st_ff.ptr;
endmodule : rsx_stack

// ===== sim/rsx_exec_checker.sv
/* port assertions for the return-stack executor.
   assumes the bind at the foot attaches it to every rsx_exec. */
module rsx_exec_checker
    import rsx_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // instruction side
    input wire logic OP_VALID,
    input wire logic [15:0] OPCODE,
    input wire logic [rsx_pkg::PC_W-1:0] PC_IN,
    input wire logic HIGH_PRIO_ACTIVE,
    input wire logic [4:0] FLAGS_IN,
    input wire logic [3:0] BANK_IN,
    // results
    input wire logic [rsx_pkg::PC_W-1:0] PC_OUT,
    input wire logic PC_LOAD,
    input wire logic BUSY,
    input wire logic SOFT_RESET,
    input wire logic [7:0] WORKING,
    input wire logic [4:0] FLAGS,
    input wire logic [3:0] BANK_SELECT_REG,
    input wire logic [7:0] WORKING_SHADOW,
    input wire logic [4:0] FLAGS_SHADOW,
    input wire logic [3:0] BANK_SELECT_SHADOW,
    input wire logic HIGH_PRIO_GLOBAL_ENABLE,
    input wire logic LOW_PRIO_GLOBAL_ENABLE,
    input wire logic [rsx_pkg::PC_W-1:0] STACK_TOP
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire logic tk = OP_VALID && !BUSY && !SOFT_RESET;
    wire logic rc = OPCODE[15:11] == RELATIVE_CALL_OP_HI;
    wire logic rf = OPCODE[15:1] == RETURN_FROM_IRQ_OP_HI;
    wire logic [PC_W-1:0] tgt = PC_IN + PC_STEP
        + {{9{OPCODE[10]}}, OPCODE[10:0], 1'b0};
    property p_ret_addr;
        tk && (OPCODE == OP_PUSH || rc) |->
            ##2 STACK_TOP == $past(PC_IN, 2) + PC_STEP;
    endproperty
    a_ret_addr: assert property (p_ret_addr)
        else $error("bad return addr");
    property p_relative_call_op;
        tk && rc |=> PC_LOAD && BUSY && PC_OUT == $past(tgt);
    endproperty
    a_relative_call_op: assert property (p_relative_call_op)
        else $error("bad call target");
    property p_ign;
        BUSY && OP_VALID |=> !PC_LOAD && !BUSY && !SOFT_RESET;
    endproperty
    a_ign: assert property (p_ign)
        else $error("opcode taken in idle");
    property p_return_with_literal_op;
        tk && OPCODE[15:8] == RETURN_WITH_LITERAL_OP_HI |=>
            WORKING == $past(OPCODE[7:0]) && PC_LOAD && BUSY;
    endproperty
    a_return_with_literal_op: assert property (p_return_with_literal_op)
        else $error("bad literal return");
    property p_en;
        tk && rf |=> PC_LOAD && BUSY && ($past(HIGH_PRIO_ACTIVE)
            ? HIGH_PRIO_GLOBAL_ENABLE : LOW_PRIO_GLOBAL_ENABLE);
    endproperty
    a_en: assert property (p_en)
        else $error("enable not set");
    property p_fast;
        tk && rf && OPCODE[0] |=> WORKING == $past(WORKING_SHADOW)
            && FLAGS == $past(FLAGS_SHADOW)
            && BANK_SELECT_REG == $past(BANK_SELECT_SHADOW);
    endproperty
    a_fast: assert property (p_fast)
        else $error("shadows not restored");
    property p_slow;
        tk && rf && !OPCODE[0] |=> FLAGS == $past(FLAGS_IN)
            && BANK_SELECT_REG == $past(BANK_IN);
    endproperty
    a_slow: assert property (p_slow)
        else $error("live regs disturbed");
    property p_srst;
        tk && OPCODE == OP_RESET |=> SOFT_RESET
            ##1 PC_LOAD && PC_OUT == PC_RST
            && WORKING == BYTE_RST && !HIGH_PRIO_GLOBAL_ENABLE;
    endproperty
    a_srst: assert property (p_srst)
        else $error("soft reset wrong");
    property p_pop;
        tk && OPCODE == OP_POP |=> !PC_LOAD && !BUSY;
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop moved the pc");
    c_relative_call_op: cover property (tk && rc);
    c_fast: cover property (tk && rf && OPCODE[0]);
    c_srst: cover property (tk && OPCODE == OP_RESET);
endmodule : rsx_exec_checker

bind rsx_exec rsx_exec_checker u_chk (.*);

// ===== sim/tb_rsx_exec.sv
/* self-checking bench for the return-stack executor.
   assumes the checker is bound; drives all ports directly. */
module tb_rsx_exec
    import rsx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 0, RST = 1, OP_VALID = 0, HIGH_PRIO_ACTIVE = 0;
    logic STACK_TOP_WR = 0, WORKING_WR = 0, SHADOW_WR = 0, ENABLES_CLR = 0;
    logic [15:0] OPCODE = 0;
    logic [PC_W-1:0] PC_IN = 0, STACK_TOP_WDATA = 0, PC_OUT, STACK_TOP;
    logic [7:0] WORKING_WDATA = 0, WORKING, WORKING_SHADOW;
    logic [4:0] FLAGS_IN = 0, FLAGS, FLAGS_SHADOW;
    logic [3:0] BANK_IN = 0, BANK_SELECT_REG, BANK_SELECT_SHADOW;
    logic PC_LOAD, BUSY, SOFT_RESET;
    logic HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE;
    logic [PTR_W-1:0] STACK_PTR;
    logic [PC_W-1:0] exp_q[$], stk[$], pc, v;
    logic [18:0] snap, c1;
    logic [10:0] ofs[3];
    logic [7:0] k, w[2];
    logic [8:0] fb[2];
    int n_mismatch = 0, check_count = 0;
    integer seed = 32'habd62d30;
    rsx_exec uut (.*);
    initial forever #20 REF_CLK = ~REF_CLK;
    always @(negedge REF_CLK) snap = {WORKING, FLAGS, BANK_SELECT_REG,
        HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE};
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // scoreboard: every pc load takes the oldest expected target
    always @(negedge REF_CLK) if (PC_LOAD === 1'b1) begin
        if (exp_q.size() == 0) chk(PC_LOAD, 0);
        else chk(PC_OUT, exp_q.pop_front());
    end
    function automatic logic [PC_W-1:0] rnd();
        return PC_W'($random(seed)) & ~PC_W'(1);
    endfunction : rnd
    task automatic op(input logic [15:0] code, input int hold);
        @(posedge REF_CLK);
        OPCODE <= code;
        PC_IN <= pc;
        OP_VALID <= 1'b1;
        repeat (hold) @(posedge REF_CLK);
        OP_VALID <= 1'b0;
        @(posedge REF_CLK);
        c1 = snap;
        #1;
    endtask : op
    task automatic regs(input logic [7:0] wd, input logic [8:0] f, input sh);
        @(posedge REF_CLK);
        WORKING_WR <= 1'b1;
        WORKING_WDATA <= wd;
        {FLAGS_IN, BANK_IN} <= f;
        SHADOW_WR <= sh;
        ENABLES_CLR <= 1'b1;
        @(posedge REF_CLK);
        {WORKING_WR, SHADOW_WR, ENABLES_CLR} <= 3'h0;
    endtask : regs
    initial begin
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            pc = rnd();
            op(OP_PUSH, 2);
            stk.push_front(pc + PC_STEP);
            stk.push_front(pc + PC_STEP);
            chk(STACK_TOP, stk[0]);
            chk(STACK_PTR, stk.size());
        end
        v = rnd();
        @(posedge REF_CLK);
        STACK_TOP_WR <= 1'b1;
        STACK_TOP_WDATA <= v;
        @(posedge REF_CLK);
        STACK_TOP_WR <= 1'b0;
        stk[0] = v;
        op(OP_PUSH, 1);
        op(OP_POP, 1);
        chk(STACK_TOP, v);
        ofs = '{11'h400, 11'h3ff, 11'($random(seed))};
        for (int i = 0; i < 3; i++) begin
            pc = rnd();
            exp_q.push_back(pc + PC_STEP + {{9{ofs[i][10]}}, ofs[i], 1'b0});
            op({RELATIVE_CALL_OP_HI, ofs[i]}, 2);
            stk.push_front(pc + PC_STEP);
            chk(STACK_TOP, stk[0]);
        end
        for (int i = 0; i < 2; i++) begin
            k = 8'($random(seed));
            exp_q.push_back(stk.pop_front());
            op({RETURN_WITH_LITERAL_OP_HI, k}, 1);
            chk(c1[18:11], k);
            chk(STACK_PTR, stk.size());
        end
        for (int s = 0; s < 2; s++) begin
            {w[0], w[1], fb[0], fb[1]} = 34'({$random(seed), $random(seed)});
            regs(w[1], 9'h0, 1'b0);
            regs(w[0], fb[1], 1'b1);
            #1 chk({WORKING_SHADOW, FLAGS_SHADOW, BANK_SELECT_SHADOW},
                {w[1], fb[1]});
            regs(w[0], fb[0], 1'b0);
            @(posedge REF_CLK) HIGH_PRIO_ACTIVE <= s[0];
            exp_q.push_back(stk.pop_front());
            op({RETURN_FROM_IRQ_OP_HI, s[0]}, 1);
            chk(c1, {w[s], fb[s], s[0], !s[0]});
        end
        pc = rnd();
        exp_q.push_back(PC_RST);
        op(OP_RESET, 1);
        @(posedge REF_CLK);
        #1;
        chk({STACK_PTR, WORKING, HIGH_PRIO_GLOBAL_ENABLE}, 0);
        repeat (3) @(posedge REF_CLK);
        chk(exp_q.size(), 0);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge REF_CLK);
        n_mismatch++;
        test_done();
    end
endmodule : tb_rsx_exec
